// ### cpu_alu_regs.vh
// Constants of the integer execution datapath
`ifndef CPU_ALU_REGS_VH
`define CPU_ALU_REGS_VH

// ----------------------------------------------------------------
// Operand sizes
// ----------------------------------------------------------------
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define OP_ADD 5'h00
`define OP_SUB 5'h01
`define OP_ADD_WITH_CARRY 5'h02
`define OP_SUBTRACT_WITH_CARRY 5'h03
`define OP_STEP_UP 5'h04
`define OP_STEP_DOWN 5'h05
`define OP_ADD_SMALL_CONST_LONG 5'h06
`define OP_SUBTRACT_SMALL_CONST_LONG 5'h07
`define OP_DECIMAL_ADJUST_AFTER_ADD 5'h08
`define OP_DECIMAL_ADJUST_AFTER_SUB 5'h09
`define OP_UNSIGNED_MULTIPLY 5'h0a
`define OP_SIGNED_MULTIPLY 5'h0b
`define OP_UNSIGNED_DIVIDE 5'h0c
`define OP_AND 5'h0d
`define OP_OR 5'h0e
`define OP_XOR 5'h0f
`define OP_NOT 5'h10
`define OP_ARITH_SHIFT_LEFT 5'h11
`define OP_ARITH_SHIFT_RIGHT 5'h12
`define OP_LOGIC_SHIFT_LEFT 5'h13
`define OP_LOGIC_SHIFT_RIGHT 5'h14
`define OP_ROTATE_LEFT 5'h15
`define OP_ROTATE_RIGHT 5'h16
`define OP_ROTATE_LEFT_THRU_CARRY 5'h17
`define OP_ROTATE_RIGHT_THRU_CARRY 5'h18

// ----------------------------------------------------------------
// Flag register fields and reset value
// ----------------------------------------------------------------
`define FLAG_C 0
`define FLAG_V 1
`define FLAG_Z 2
`define FLAG_N 3
`define FLAG_H 5
`define FLAG_I 7
`define FLAG_RESET 8'h80

// ----------------------------------------------------------------
// Decimal adjust constants
// ----------------------------------------------------------------
`define BCD_ADJ_LO 8'h06
`define BCD_ADJ_HI 8'h60
`define BCD_MAX_BYTE 8'h99
`define BCD_MAX_DIGIT 4'h9

`endif

// ### alu_divider.v
// Restoring unsigned divider, one quotient bit per clock
`timescale 1ns/100ps

module alu_divider #(
    parameter W = 16
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire start_i,
    input wire [2*W-1:0] dividend_i,
    input wire [W-1:0] divisor_i,
    output reg busy_o,
    output reg done_o,
    output wire [W-1:0] quotient_o,
    output wire [W-1:0] remainder_o
);

    reg [2*W:0] acc_q;
    reg [2*W:0] acc_d;
    reg [5:0] cnt_q;

    // ------------------------------------------------------------
    // One shift and trial subtraction
    // ------------------------------------------------------------
    always @* begin
        acc_d = {acc_q[2*W-1:0], 1'b0};
        if (acc_d[2*W:W] >= {1'b0, divisor_i}) begin
            acc_d[2*W:W] = acc_d[2*W:W] - {1'b0, divisor_i};
            acc_d[0] = 1'b1;
        end
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            acc_q <= {(2*W+1){1'b0}};
            cnt_q <= 6'h00;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                acc_q <= {1'b0, dividend_i};
                cnt_q <= W[5:0];
                busy_o <= 1'b1;
            end else if (busy_o) begin
                acc_q <= acc_d;
                cnt_q <= cnt_q - 6'h01;
                if (cnt_q == 6'h01) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

    assign quotient_o = acc_q[W-1:0];
    assign remainder_o = acc_q[2*W-1:W];

endmodule

// ### cpu_alu_shift_datapath.v
// Integer execution datapath with its general register file
`timescale 1ns/100ps
`include "cpu_alu_regs.vh"

// Function
// - Sixteen general registers of 16 bits feed and receive datapath results.
// - Add or subtract register or literal, byte/word/long; no byte literal subtract.
// - Byte-only add and subtract with carry, register or literal operand.
// - Step up or down by 1 or 2; bytes by 1 only.
// - Add or subtract 1, 2 or 4 on a 32-bit register only.
// - Decimal adjust a byte after add or subtract using the flags.
// - Unsigned multiply 8x8 to 16 or 16x16 to 32 bits.
// - Signed multiply with the same operand and product widths.
// - Unsigned divide 16/8 or 32/16 giving quotient and remainder.
// - Bitwise AND with register or literal, any size.
// - Bitwise OR with register or literal, any size.
// - Bitwise exclusive OR with register or literal, any size.
// - One's complement of a register, any size.
// - Arithmetic shift by one; right shift keeps the sign bit.
// - Logical shift by one, vacated bit gets zero.
// - Rotate by one, leaving bit re-enters at other end.
// - Rotate by one through the carry flag.
module cpu_alu_shift_datapath #(
    parameter NREG = 16,
    parameter DW = 16
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire op_valid_i,
    input wire [4:0] op_code_i,
    input wire [1:0] op_size_i,
    input wire [3:0] dst_reg_i,
    input wire [3:0] source_reg_i,
    input wire use_literal_i,
    input wire [31:0] literal_operand_i,
    input wire [2:0] step_amt_i,
    input wire load_en_i,
    input wire [3:0] load_reg_i,
    input wire [15:0] load_data_i,
    input wire flag_load_en_i,
    input wire [7:0] flag_load_i,
    input wire [3:0] peek_reg_i,
    output reg [15:0] peek_data_o,
    output reg [7:0] flag_register_o,
    output reg [31:0] result_o,
    output reg busy_o,
    output reg done_o,
    output reg illegal_o
);

    localparam ST_IDLE = 2'b01;
    localparam ST_DIV = 2'b10;

    reg [DW-1:0] regs [0:NREG-1];
    reg [1:0] state_q, div_sz_q;
    reg [3:0] div_dst_q;

    reg [1:0] dsz, fsz, wr_sz;
    reg [3:0] wr_idx;
    reg [7:0] ccr_d;
    reg [31:0] mk, a_val, b_val, bb, res, nzv, wr_val;
    reg [32:0] raw;
    reg sub, cin, upd_nz, upd_v, upd_c, upd_h, vf, cf, hf, wr, bad;
    reg adj_lo, adj_hi, fill, wr_go;
    integer i;

    wire take = op_valid_i && !busy_o && state_q == ST_IDLE;
    wire div_busy, div_done;
    wire [15:0] div_quo, div_rem;

    // ------------------------------------------------------------
    // Size helpers
    // ------------------------------------------------------------
    function [31:0] size_mask(input [1:0] s);
        case (s)
            `SZ_BYTE: size_mask = 32'h000000ff;
            `SZ_WORD: size_mask = 32'h0000ffff;
            default: size_mask = 32'hffffffff;
        endcase
    endfunction

    function [31:0] top_bit(input [1:0] s);
        top_bit = size_mask(s) & ~(size_mask(s) >> 1);
    endfunction

    function msb_of(input [31:0] v, input [1:0] s);
        msb_of = |(v & top_bit(s));
    endfunction

    function [31:0] set_msb(input [31:0] v, input [1:0] s, input b);
        set_msb = b ? v | top_bit(s) : v & ~top_bit(s);
    endfunction

    function carry_at(input [32:0] v, input [1:0] s);
        carry_at = |(v & {top_bit(s), 1'b0});
    endfunction

    function half_at(input [32:0] v, input [1:0] s);
        half_at = |(v[31:0] & (top_bit(s) >> 3));
    endfunction

    // ------------------------------------------------------------
    // Operand fetch
    // ------------------------------------------------------------
    always @* begin
        dsz = op_size_i + {1'b0, op_code_i >= `OP_UNSIGNED_MULTIPLY &&
            op_code_i <= `OP_UNSIGNED_DIVIDE};
        mk = size_mask(op_size_i);
        case (dsz)
            `SZ_BYTE: a_val = dst_reg_i[3] ?
                {24'h000000, regs[{1'b0, dst_reg_i[2:0]}][7:0]} :
                {24'h000000, regs[{1'b0, dst_reg_i[2:0]}][15:8]};
            `SZ_WORD: a_val = {16'h0000, regs[dst_reg_i]};
            default: a_val = {regs[{1'b1, dst_reg_i[2:0]}],
                regs[{1'b0, dst_reg_i[2:0]}]};
        endcase
        if (use_literal_i)
            b_val = literal_operand_i & mk;
        else
            case (op_size_i)
                `SZ_BYTE: b_val = source_reg_i[3] ?
                    {24'h000000, regs[{1'b0, source_reg_i[2:0]}][7:0]} :
                    {24'h000000, regs[{1'b0, source_reg_i[2:0]}][15:8]};
                `SZ_WORD: b_val = {16'h0000, regs[source_reg_i]};
                default: b_val = {regs[{1'b1, source_reg_i[2:0]}],
                    regs[{1'b0, source_reg_i[2:0]}]};
            endcase
    end

    wire [15:0] mul_ub = a_val[7:0] * b_val[7:0];
    wire signed [15:0] mul_sb = $signed(a_val[7:0]) * $signed(b_val[7:0]);
    wire [31:0] mul_uw = a_val[15:0] * b_val[15:0];
    wire signed [31:0] mul_sw =
        $signed(a_val[15:0]) * $signed(b_val[15:0]);

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    always @* begin
        sub = op_code_i[0] && op_code_i <= `OP_SUBTRACT_SMALL_CONST_LONG;
        cin = (op_code_i | 5'h01) == `OP_SUBTRACT_WITH_CARRY &&
            flag_register_o[`FLAG_C];
        bb = op_code_i[4:2] == 3'h1 ? {29'h0, step_amt_i} : b_val & mk;
        raw = sub ? {1'b0, a_val} - {1'b0, bb} - {32'h00000000, cin} :
            {1'b0, a_val} + {1'b0, bb} + {32'h00000000, cin};
        res = raw[31:0] & mk;
        nzv = res;
        fsz = op_size_i;
        {upd_nz, upd_v, upd_c, upd_h} = 4'he;
        vf = 1'b0;
        cf = carry_at(raw ^ {1'b0, a_val} ^ {1'b0, bb}, op_size_i);
        hf = half_at(raw ^ {1'b0, a_val} ^ {1'b0, bb}, op_size_i);
        wr = 1'b1;
        bad = op_size_i == 2'h3;
        {adj_lo, adj_hi, fill} = 3'h0;
        case (op_code_i)
            `OP_ADD, `OP_SUB, `OP_ADD_WITH_CARRY,
            `OP_SUBTRACT_WITH_CARRY: begin
                if (op_code_i[1])
                    bad = op_size_i != `SZ_BYTE;
                else
                    bad = bad || (sub && use_literal_i &&
                        op_size_i == `SZ_BYTE);
                upd_h = 1'b1;
                vf = (msb_of(a_val, op_size_i) ^ sub ^
                    msb_of(bb, op_size_i)) == 1'b0 &&
                    msb_of(res, op_size_i) != msb_of(a_val, op_size_i);
            end
            `OP_STEP_UP, `OP_STEP_DOWN: begin
                bad = bad || !(step_amt_i == 3'h1 ||
                    (step_amt_i == 3'h2 && op_size_i != `SZ_BYTE));
                upd_c = 1'b0;
                vf = (msb_of(a_val, op_size_i) ^ sub) == 1'b0 &&
                    msb_of(res, op_size_i) != msb_of(a_val, op_size_i);
            end
            `OP_ADD_SMALL_CONST_LONG, `OP_SUBTRACT_SMALL_CONST_LONG: begin
                bad = op_size_i != `SZ_LONG || !(step_amt_i == 3'h1 ||
                    step_amt_i == 3'h2 || step_amt_i == 3'h4);
                {upd_nz, upd_v, upd_c} = 3'h0;
            end
            `OP_DECIMAL_ADJUST_AFTER_ADD, `OP_DECIMAL_ADJUST_AFTER_SUB: begin
                bad = op_size_i != `SZ_BYTE;
                adj_lo = flag_register_o[`FLAG_H] ||
                    (!op_code_i[0] && a_val[3:0] > `BCD_MAX_DIGIT);
                adj_hi = flag_register_o[`FLAG_C] ||
                    (!op_code_i[0] && a_val[7:0] > `BCD_MAX_BYTE);
                res = {24'h000000, (adj_hi ? `BCD_ADJ_HI : 8'h00) |
                    (adj_lo ? `BCD_ADJ_LO : 8'h00)};
                res = (op_code_i[0] ? a_val - res : a_val + res) & mk;
                cf = adj_hi;
                nzv = res;
            end
            `OP_UNSIGNED_MULTIPLY, `OP_SIGNED_MULTIPLY: begin
                bad = bad || op_size_i == `SZ_LONG;
                if (op_code_i[0])
                    res = op_size_i == `SZ_BYTE ? {16'h0000, mul_sb} : mul_sw;
                else
                    res = op_size_i == `SZ_BYTE ? {16'h0000, mul_ub} : mul_uw;
                nzv = res;
                fsz = dsz;
                {upd_nz, upd_v, upd_c} = {op_code_i[0], 2'h0};
            end
            `OP_UNSIGNED_DIVIDE: begin
                bad = bad || op_size_i == `SZ_LONG;
                wr = 1'b0;
                nzv = b_val;
                {upd_v, upd_c} = 2'h0;
            end
            `OP_AND, `OP_OR, `OP_XOR, `OP_NOT: begin
                case (op_code_i)
                    `OP_AND: res = a_val & bb;
                    `OP_OR: res = a_val | bb;
                    `OP_XOR: res = a_val ^ bb;
                    default: res = ~a_val & mk;
                endcase
                nzv = res;
                upd_c = 1'b0;
            end
            `OP_ARITH_SHIFT_LEFT, `OP_LOGIC_SHIFT_LEFT, `OP_ROTATE_LEFT,
            `OP_ROTATE_LEFT_THRU_CARRY: begin
                cf = msb_of(a_val, op_size_i);
                res = ((a_val << 1) & mk) | {31'h00000000,
                    (op_code_i == `OP_ROTATE_LEFT && cf) ||
                    (op_code_i == `OP_ROTATE_LEFT_THRU_CARRY &&
                    flag_register_o[`FLAG_C])};
                vf = op_code_i == `OP_ARITH_SHIFT_LEFT &&
                    msb_of(res, op_size_i) != cf;
                nzv = res;
            end
            `OP_ARITH_SHIFT_RIGHT, `OP_LOGIC_SHIFT_RIGHT, `OP_ROTATE_RIGHT,
            `OP_ROTATE_RIGHT_THRU_CARRY: begin
                cf = a_val[0];
                if (op_code_i == `OP_ARITH_SHIFT_RIGHT)
                    fill = msb_of(a_val, op_size_i);
                else if (op_code_i == `OP_ROTATE_RIGHT)
                    fill = a_val[0];
                else if (op_code_i == `OP_ROTATE_RIGHT_THRU_CARRY)
                    fill = flag_register_o[`FLAG_C];
                res = set_msb(a_val >> 1, op_size_i, fill);
                nzv = res;
            end
            default: bad = 1'b1;
        endcase
        ccr_d = flag_register_o;
        if (upd_nz) begin
            ccr_d[`FLAG_N] = msb_of(nzv, fsz);
            ccr_d[`FLAG_Z] = (nzv & size_mask(fsz)) == 32'h00000000;
        end
        if (upd_v)
            ccr_d[`FLAG_V] = vf;
        if (upd_c)
            ccr_d[`FLAG_C] = cf;
        if (upd_h)
            ccr_d[`FLAG_H] = hf;
    end

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    alu_divider #(
        .W(16)
    ) u_div (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .start_i(take && !bad && op_code_i == `OP_UNSIGNED_DIVIDE),
        .dividend_i(a_val),
        .divisor_i(b_val[15:0]),
        .busy_o(div_busy),
        .done_o(div_done),
        .quotient_o(div_quo),
        .remainder_o(div_rem)
    );

    // ------------------------------------------------------------
    // Write-back selection
    // ------------------------------------------------------------
    always @* begin
        if (state_q == ST_DIV) begin
            wr_go = div_done;
            wr_idx = div_dst_q;
            wr_sz = div_sz_q;
            wr_val = div_sz_q == `SZ_WORD ?
                {16'h0000, div_rem[7:0], div_quo[7:0]} : {div_rem, div_quo};
        end else begin
            wr_go = take && !bad && wr;
            wr_idx = dst_reg_i;
            wr_sz = dsz;
            wr_val = res;
        end
    end

    // ------------------------------------------------------------
    // Register file, flags and control
    // ------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            for (i = 0; i < NREG; i = i + 1)
                regs[i] <= {DW{1'b0}};
            state_q <= ST_IDLE;
            div_dst_q <= 4'h0;
            div_sz_q <= `SZ_BYTE;
            peek_data_o <= 16'h0000;
            flag_register_o <= `FLAG_RESET;
            result_o <= 32'h00000000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            illegal_o <= 1'b0;
        end else begin
            peek_data_o <= regs[peek_reg_i];
            done_o <= 1'b0;
            illegal_o <= 1'b0;
            if (load_en_i)
                regs[load_reg_i] <= load_data_i;
            if (flag_load_en_i)
                flag_register_o <= flag_load_i;
            if (wr_go) begin
                case (wr_sz)
                    `SZ_BYTE: begin
                        if (wr_idx[3])
                            regs[{1'b0, wr_idx[2:0]}][7:0] <= wr_val[7:0];
                        else
                            regs[{1'b0, wr_idx[2:0]}][15:8] <= wr_val[7:0];
                    end
                    `SZ_WORD: regs[wr_idx] <= wr_val[15:0];
                    default: begin
                        regs[{1'b0, wr_idx[2:0]}] <= wr_val[15:0];
                        regs[{1'b1, wr_idx[2:0]}] <= wr_val[31:16];
                    end
                endcase
                result_o <= wr_val;
            end
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        if (bad) begin
                            illegal_o <= 1'b1;
                            done_o <= 1'b1;
                        end else begin
                            flag_register_o <= ccr_d;
                            if (op_code_i == `OP_UNSIGNED_DIVIDE) begin
                                state_q <= ST_DIV;
                                busy_o <= 1'b1;
                                div_dst_q <= dst_reg_i;
                                div_sz_q <= dsz;
                            end else
                                done_o <= 1'b1;
                        end
                    end
                end
                ST_DIV: begin
                    if (div_done && !div_busy) begin
                        state_q <= ST_IDLE;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule

// ### alu_chk_sva.sv
// Port assertions of the integer datapath
`timescale 1ns/100ps
`include "cpu_alu_regs.vh"
module alu_chk (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire op_valid_i,
    input wire [4:0] op_code_i,
    input wire [1:0] op_size_i,
    input wire use_literal_i,
    input wire [2:0] step_amt_i,
    input wire flag_load_en_i,
    input wire [7:0] flag_register_o,
    input wire busy_o,
    input wire done_o,
    input wire illegal_o
);
    // ------------------------------------------------
    // Request checks
    // ------------------------------------------------
    wire tk = op_valid_i && !busy_o;
    // Upper four code bits select a pair of related operations
    wire [3:0] pr = op_code_i[4:1];
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_ref;
        done_o && illegal_o;
    endsequence
    sequence s_div;
        (busy_o && !done_o)[*8] ##10 done_o;
    endsequence
    AST_DONE: assert property (
        tk && op_code_i != `OP_UNSIGNED_DIVIDE |=> done_o)
        else $error("request not completed");
    AST_DIV_TIME: assert property (
        tk && op_code_i == `OP_UNSIGNED_DIVIDE && op_size_i < `SZ_LONG
        |=> s_div) else $error("divide timing wrong");
    AST_SUB_LIT: assert property (
        tk && op_code_i == `OP_SUB && op_size_i == `SZ_BYTE && use_literal_i
        |=> s_ref) else $error("byte literal subtract accepted");
    AST_CARRY_SZ: assert property (
        tk && pr == 4'h1 && op_size_i != `SZ_BYTE |=> s_ref)
        else $error("wide carry op accepted");
    AST_STEP_BYTE: assert property (
        tk && pr == 4'h2 && op_size_i == `SZ_BYTE && step_amt_i == 3'h2
        |=> s_ref) else $error("byte step by two accepted");
    AST_CONST_LONG: assert property (
        tk && pr == 4'h3 && op_size_i != `SZ_LONG |=> s_ref)
        else $error("short constant op accepted");
    AST_BCD_BYTE: assert property (
        tk && pr == 4'h4 && op_size_i != `SZ_BYTE |=> s_ref)
        else $error("wide decimal adjust accepted");
    AST_MUL_LONG: assert property (
        tk && pr == 4'h5 && op_size_i == `SZ_LONG |=> s_ref)
        else $error("long multiply accepted");
    AST_LOGIC_V: assert property (
        tk && op_code_i >= `OP_AND && op_code_i <= `OP_NOT && op_size_i != 2'h3
        |=> done_o && !illegal_o && !flag_register_o[`FLAG_V])
        else $error("logic op flags wrong");
    AST_REF_FLAGS: assert property (
        illegal_o && !$past(flag_load_en_i) |-> $stable(flag_register_o))
        else $error("refused op changed flags");
endmodule

bind cpu_alu_shift_datapath alu_chk alu_chk_i (.clk_sys_i, .sys_rst_i,
    .op_valid_i, .op_code_i, .op_size_i, .use_literal_i, .step_amt_i,
    .flag_load_en_i, .flag_register_o, .busy_o, .done_o, .illegal_o);

// ### decoder_model.sv
// Issue side model driving operation requests
`timescale 1ns/100ps
module decoder_model (
    input wire clk_sys_i,
    input wire done_i,
    input wire illegal_i,
    output logic op_valid_o,
    output logic [4:0] op_code_o,
    output logic [1:0] op_size_o,
    output logic [3:0] dst_o,
    output logic [3:0] src_o,
    output logic use_lit_o,
    output logic [31:0] lit_o,
    output logic [2:0] amt_o
);
    logic ill;
    integer n;
    initial begin
        op_valid_o = 1'b0;
        {op_code_o, op_size_o, dst_o, src_o, use_lit_o, lit_o, amt_o} = '0;
    end
    // Holds one request for a single taking edge, then waits for completion
    task issue(input [4:0] c, input [1:0] s, input [3:0] d, input [3:0] r,
               input u, input [31:0] l, input [2:0] a);
        begin
            @(negedge clk_sys_i);
            {op_code_o, op_size_o, dst_o, src_o, use_lit_o, lit_o, amt_o} =
                {c, s, d, r, u, l, a};
            op_valid_o = 1'b1;
            @(negedge clk_sys_i);
            op_valid_o = 1'b0;
            op_code_o = ~c;
            n = 0;
            while (done_i !== 1'b1 && n < 40) begin
                @(negedge clk_sys_i);
                n = n + 1;
            end
            ill = done_i ? illegal_i : 1'bx;
        end
    endtask
endmodule

// ### cpu_alu_shift_datapath_bench.sv
// Self-checking bench of the integer datapath
`timescale 1ns/100ps
`include "cpu_alu_regs.vh"
module cpu_alu_shift_datapath_bench;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ld_en = 1'b0;
    logic fl_en = 1'b0;
    logic [3:0] ld_reg = 4'h0;
    logic [3:0] pk_reg = 4'h0;
    logic [15:0] ld_dat = 16'h0000;
    logic [7:0] fl_dat = 8'h00;
    logic [15:0] sh_exp [0:7] = '{16'h0002, 16'hc000, 16'h0002, 16'h4000,
        16'h0003, 16'hc000, 16'h0002, 16'h4000};
    wire vld, ul, busy, done, ill;
    wire [4:0] code;
    wire [1:0] sz;
    wire [3:0] dst, src;
    wire [31:0] lit, res;
    wire [2:0] amt;
    wire [15:0] pkd;
    wire [7:0] flg;
    integer n_fail = 0;
    integer num_checks = 0;
    integer i;
    always #50 clk_sys_i = ~clk_sys_i;
    cpu_alu_shift_datapath cpu_alu_shift_datapath_i (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .op_valid_i(vld), .op_code_i(code),
        .op_size_i(sz), .dst_reg_i(dst), .source_reg_i(src),
        .use_literal_i(ul), .literal_operand_i(lit), .step_amt_i(amt),
        .load_en_i(ld_en), .load_reg_i(ld_reg), .load_data_i(ld_dat),
        .flag_load_en_i(fl_en), .flag_load_i(fl_dat), .peek_reg_i(pk_reg),
        .peek_data_o(pkd), .flag_register_o(flg), .result_o(res),
        .busy_o(busy), .done_o(done), .illegal_o(ill));
    decoder_model decoder_model_i (.clk_sys_i(clk_sys_i), .done_i(done),
        .illegal_i(ill), .op_valid_o(vld), .op_code_o(code), .op_size_o(sz),
        .dst_o(dst), .src_o(src), .use_lit_o(ul), .lit_o(lit), .amt_o(amt));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task ld(input [3:0] r, input [15:0] d);
        begin
            @(negedge clk_sys_i);
            {ld_en, ld_reg, ld_dat} = {1'b1, r, d};
            @(negedge clk_sys_i);
            ld_en = 1'b0;
        end
    endtask
    task fl(input [7:0] v);
        begin
            @(negedge clk_sys_i);
            {fl_en, fl_dat} = {1'b1, v};
            @(negedge clk_sys_i);
            fl_en = 1'b0;
        end
    endtask
    task pk(input [3:0] r, input [15:0] e);
        begin
            @(negedge clk_sys_i);
            pk_reg = r;
            @(negedge clk_sys_i);
            chk(pkd, e);
        end
    endtask
    task op(input [4:0] c, input [1:0] s, input [3:0] d, input [3:0] r,
            input u, input [31:0] l, input [2:0] a, input e);
        begin
            decoder_model_i.issue(c, s, d, r, u, l, a);
            chk(decoder_model_i.ill, e);
        end
    endtask
    task t_addsub;
        begin
            chk(flg, 8'h80);
            ld(0, 16'h1234);
            ld(1, 16'h0fff);
            op(`OP_ADD, `SZ_WORD, 0, 1, 0, 0, 0, 0);
            chk(res[15:0], 16'h2233);
            op(`OP_SUB, `SZ_BYTE, 8, 0, 1, 1, 0, 1);
            pk(0, 16'h2233);
            fl(8'h01);
            op(`OP_ADD_WITH_CARRY, `SZ_BYTE, 8, 0, 1, 1, 0, 0);
            pk(0, 16'h2235);
            fl(8'h01);
            op(`OP_SUBTRACT_WITH_CARRY, `SZ_BYTE, 8, 0, 1, 1, 0, 0);
            pk(0, 16'h2233);
            op(`OP_ADD_WITH_CARRY, `SZ_WORD, 0, 1, 0, 0, 0, 1);
        end
    endtask
    task t_step;
        begin
            op(`OP_STEP_DOWN, `SZ_BYTE, 8, 0, 0, 0, 2, 1);
            op(`OP_STEP_UP, `SZ_WORD, 1, 0, 0, 0, 2, 0);
            pk(1, 16'h1001);
            ld(0, 16'h0002);
            op(`OP_SUBTRACT_SMALL_CONST_LONG, `SZ_LONG, 0, 0, 0, 0, 4, 0);
            pk(8, 16'hffff);
            op(`OP_ADD_SMALL_CONST_LONG, `SZ_LONG, 0, 0, 0, 0, 1, 0);
            pk(0, 16'hffff);
            op(`OP_ADD_SMALL_CONST_LONG, `SZ_WORD, 0, 0, 0, 0, 1, 1);
        end
    endtask
    task t_muldiv;
        begin
            ld(2, 16'h8000);
            ld(3, 16'h0004);
            op(`OP_UNSIGNED_MULTIPLY, `SZ_WORD, 2, 3, 0, 0, 0, 0);
            pk(10, 16'h0002);
            ld(4, 16'h00fe);
            ld(5, 16'h0003);
            op(`OP_SIGNED_MULTIPLY, `SZ_BYTE, 4, 13, 0, 0, 0, 0);
            pk(4, 16'hfffa);
            ld(6, 16'h0064);
            ld(7, 16'h0007);
            op(`OP_UNSIGNED_DIVIDE, `SZ_BYTE, 6, 15, 0, 0, 0, 0);
            pk(6, 16'h020e);
            ld(5, 16'h003c);
            fl(8'h00);
            op(`OP_DECIMAL_ADJUST_AFTER_ADD, `SZ_BYTE, 13, 0, 0, 0, 0, 0);
            pk(5, 16'h0042);
            ld(5, 16'h0048);
            fl(8'h20);
            op(`OP_DECIMAL_ADJUST_AFTER_SUB, `SZ_BYTE, 13, 0, 0, 0, 0, 0);
            pk(5, 16'h0042);
        end
    endtask
    task t_logic;
        begin
            ld(11, 16'h1001);
            op(`OP_AND, `SZ_WORD, 11, 0, 1, 32'h00ff, 0, 0);
            pk(11, 16'h0001);
            op(`OP_OR, `SZ_WORD, 11, 0, 1, 32'h00ff, 0, 0);
            pk(11, 16'h00ff);
            op(`OP_XOR, `SZ_WORD, 11, 0, 1, 32'h00ff, 0, 0);
            pk(11, 16'h0000);
            chk(flg[`FLAG_Z], 1'b1);
            op(`OP_NOT, `SZ_WORD, 11, 0, 0, 0, 0, 0);
            pk(11, 16'hffff);
        end
    endtask
    task t_shift;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                ld(12, 16'h8001);
                fl(8'h00);
                op(`OP_ARITH_SHIFT_LEFT + i, `SZ_WORD, 12, 0, 0, 0, 0, 0);
                pk(12, sh_exp[i]);
                chk(flg[`FLAG_C], 1'b1);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        t_addsub;
        t_step;
        t_muldiv;
        t_logic;
        t_shift;
        test_done;
    end
    initial begin
        #200000;
        n_fail = n_fail + 1;
        test_done;
    end
endmodule
